/* rcc_pkg.sv */
`default_nettype none
package rcc_pkg;
	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int CLK_HZ = 25_000_000;
	localparam int POR_MS = 60;
	localparam int POR_CYC = POR_MS * (CLK_HZ / 1000);
	localparam int POR_CNT_W = 21;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] OFF_CFG0 = 8'h00;
	localparam logic [7:0] OFF_CFG1 = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_STRAP = 8'h80;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CF_SD_FORCE = 0;
	localparam int CF_SD_ON = 1;
	localparam int CF_EQ1_BYP = 2;
	localparam int CF_EQ1 = 3;
	localparam int CF_EQ2 = 6;
	localparam int CF_BW = 9;
	localparam int CF_HIGAIN = 11;
	localparam int CF_DC = 12;
	localparam int CF_LIMIT = 15;
	localparam int CF_MAIN = 0;
	localparam int CF_PRE = 5;
	localparam int CF_POST = 9;
	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG0_RST = 16'h0000;
	localparam logic [15:0] CFG1_RST = 16'h001f;
	localparam logic [15:0] CFG1_MASK = 16'h1fff;
	localparam logic [6:0] SLAVE_BASE = 7'h18;
	localparam logic [7:0] EE_DEV = 8'ha0;
	localparam logic [4:0] EE_LAST = 5'h1f;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {
		ST_POR  = 2'b00,
		ST_IDLE = 2'b01,
		ST_LOAD = 2'b10,
		ST_DONE = 2'b11
	} rcc_state_type;
endpackage
`default_nettype wire

/* rcc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module rcc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] dout_r;
	logic [W-1:0] dout_nxt;

	// A change counts only once the last two stages agree
	always_comb begin
		dout_nxt = (ff2_r == ff3_r) ? ff3_r : dout_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ff1_r <= '0;
			ff2_r <= '0;
			ff3_r <= '0;
			dout_r <= '0;
		end else begin
			ff1_r <= din;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			dout_r <= dout_nxt;
		end
	end

	assign dout = dout_r;
endmodule
`default_nettype wire

/* rcc_ctrl.sv */
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rcc_ctrl import rcc_pkg::*; #(
	parameter int PorCycles = POR_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [7:0]  sigDetect,
	input  wire logic [1:0]  addrStrapHi,
	input  wire logic [1:0]  addrStrapLo,
	input  wire logic        mgmtModeStrap,
	input  wire logic        loadReqN,
	output logic             doneNOut,
	output logic             doneNOe,
	output logic             eeReq,
	output logic [7:0]       eeDevAddr,
	output logic [9:0]       eeByteAddr,
	input  wire logic [7:0]  eeData,
	input  wire logic        eeAck,
	output logic [6:0]       slaveAddr,
	output logic [7:0]       writeByte,
	output logic [7:0]       chPowerOn,
	output logic [7:0]       eq1Bypass,
	output logic [23:0]      eq1Boost,
	output logic [23:0]      eq2Boost,
	output logic [15:0]      eqBandwidth,
	output logic [7:0]       wideGainHi,
	output logic [23:0]      dcGain,
	output logic [7:0]       limitMode,
	output logic [39:0]      firMain,
	output logic [31:0]      firPre,
	output logic [31:0]      firPost
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [7:0] sdLvl;
	logic [1:0] hiLvl;
	logic [1:0] loLvl;
	logic       modeLvl;
	logic       loadNLvl;

	rcc_sync #(.W(8)) uSyncSd (.clk(clk), .rst(rst), .din(sigDetect), .dout(sdLvl));
	rcc_sync #(.W(6)) uSyncPin (
		.clk (clk),
		.rst (rst),
		.din ({addrStrapHi, addrStrapLo, mgmtModeStrap, loadReqN}),
		.dout({hiLvl, loLvl, modeLvl, loadNLvl})
	);

	// ----------------------------------------------------------------
	// Power-on, strap capture and EEPROM self load
	// ----------------------------------------------------------------
	rcc_state_type          st_r, st_nxt;
	logic [POR_CNT_W-1:0]   porCnt_r, porCnt_nxt;
	logic [6:0]             slaveAddr_r, slaveAddr_nxt;
	logic [7:0]             writeByte_r, writeByte_nxt;
	logic                   slaveMode_r, slaveMode_nxt;
	logic [4:0]             ldIdx_r, ldIdx_nxt;
	logic                   eeReq_r, eeReq_nxt;
	logic                   doneOe_r, doneOe_nxt;
	logic                   pinReset;
	logic                   eeTake;

	// Slave-mode register reset follows the pin only once running
	assign pinReset = slaveMode_r && (st_r == ST_IDLE) && !loadNLvl;
	assign eeTake = (st_r == ST_LOAD) && eeAck;

	always_comb begin
		st_nxt = st_r;
		porCnt_nxt = porCnt_r;
		slaveAddr_nxt = slaveAddr_r;
		writeByte_nxt = writeByte_r;
		slaveMode_nxt = slaveMode_r;
		ldIdx_nxt = ldIdx_r;
		eeReq_nxt = eeReq_r;
		doneOe_nxt = doneOe_r;
		case (st_r)
			ST_POR: begin
				porCnt_nxt = porCnt_r + 1'b1;
				if (porCnt_r == POR_CNT_W'(PorCycles - 1)) begin
					// Straps are caught once here and never again
					slaveAddr_nxt = SLAVE_BASE + {3'h0, hiLvl, loLvl};
					writeByte_nxt = {slaveAddr_nxt, 1'b0};
					slaveMode_nxt = modeLvl;
					st_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				doneOe_nxt = slaveMode_r && !loadNLvl;
				if (!slaveMode_r && !loadNLvl) begin
					st_nxt = ST_LOAD;
					eeReq_nxt = 1'b1;
					ldIdx_nxt = '0;
				end
			end
			ST_LOAD: begin
				if (eeAck) begin
					if (ldIdx_r == EE_LAST) begin
						st_nxt = ST_DONE;
						eeReq_nxt = 1'b0;
						doneOe_nxt = 1'b1;
					end else begin
						ldIdx_nxt = ldIdx_r + 1'b1;
					end
				end
			end
			default: begin
				doneOe_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= ST_POR;
			porCnt_r <= '0;
			slaveAddr_r <= '0;
			writeByte_r <= '0;
			slaveMode_r <= 1'b1;
			ldIdx_r <= '0;
			eeReq_r <= 1'b0;
			doneOe_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			porCnt_r <= porCnt_nxt;
			slaveAddr_r <= slaveAddr_nxt;
			writeByte_r <= writeByte_nxt;
			slaveMode_r <= slaveMode_nxt;
			ldIdx_r <= ldIdx_nxt;
			eeReq_r <= eeReq_nxt;
			doneOe_r <= doneOe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic        awHeld_r, awHeld_nxt;
	logic        wHeld_r, wHeld_nxt;
	logic [7:0]  awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0]  wStrb_r, wStrb_nxt;
	logic        awready_r, awready_nxt;
	logic        wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        arready_r, arready_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic        busOpen;
	logic        doWrite;
	logic [5:0]  wrDec;
	logic [5:0]  rdDec;
	logic [15:0] cfg0_r [NUM_CH];
	logic [15:0] cfg1_r [NUM_CH];
	logic [15:0] cfg0_nxt [NUM_CH];
	logic [15:0] cfg1_nxt [NUM_CH];
	logic [7:0]  power_r, power_nxt;

	// Returns {hit, kind[1:0], channel[2:0]}; kind 3 is the strap register
	function automatic logic [5:0] decode(input logic [7:0] a);
		logic [5:0] d;
		d = 6'h00;
		if (a == OFF_STRAP) begin
			d = 6'h38;
		end else if (a < OFF_STRAP && a[3:0] == OFF_CFG0[3:0]) begin
			d = {3'h4, a[6:4]};
		end else if (a < OFF_STRAP && a[3:0] == OFF_CFG1[3:0]) begin
			d = {3'h5, a[6:4]};
		end else if (a < OFF_STRAP && a[3:0] == OFF_STAT[3:0]) begin
			d = {3'h6, a[6:4]};
		end
		return d;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Bus held off during power-on and while the EEPROM load runs
	assign busOpen = (st_nxt == ST_IDLE) || (st_nxt == ST_DONE);
	assign wrDec = decode(awAddr_r);
	assign rdDec = decode(araddr);
	assign doWrite = awHeld_r && wHeld_r && !bvalid_r;

	always_comb begin
		awHeld_nxt = awHeld_r || (awvalid && awready_r);
		wHeld_nxt = wHeld_r || (wvalid && wready_r);
		awAddr_nxt = (awvalid && awready_r) ? awaddr : awAddr_r;
		wData_nxt = (wvalid && wready_r) ? wdata : wData_r;
		wStrb_nxt = (wvalid && wready_r) ? wstrb : wStrb_r;
		bvalid_nxt = bvalid_r && !bready;
		bresp_nxt = bresp_r;
		if (doWrite) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wrDec[5] && wrDec[4:3] != 2'h2 && wrDec[4:3] != 2'h3) ? RESP_OK
				: RESP_ERR;
		end
		awready_nxt = !awHeld_nxt && busOpen;
		wready_nxt = !wHeld_nxt && busOpen;
		rvalid_nxt = rvalid_r && !rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = rdDec[5] ? RESP_OK : RESP_ERR;
			rdata_nxt = '0;
			case (rdDec[4:3])
				2'h0: rdata_nxt = {16'h0, cfg0_r[rdDec[2:0]]};
				2'h1: rdata_nxt = {16'h0, cfg1_r[rdDec[2:0]]};
				2'h2: rdata_nxt = {30'h0, sdLvl[rdDec[2:0]], power_r[rdDec[2:0]]};
				default: rdata_nxt = {14'h0, st_r == ST_DONE, slaveMode_r, writeByte_r,
					1'b0, slaveAddr_r};
			endcase
			if (!rdDec[5]) begin
				rdata_nxt = '0;
			end
		end
		arready_nxt = !rvalid_nxt && busOpen;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OK;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OK;
		end else begin
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel configuration
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			cfg0_nxt[c] = cfg0_r[c];
			cfg1_nxt[c] = cfg1_r[c];
			// Forced mode picks the software level, else the detector
			power_nxt[c] = cfg0_r[c][CF_SD_FORCE] ? cfg0_r[c][CF_SD_ON] : sdLvl[c];
			if (pinReset) begin
				cfg0_nxt[c] = CFG0_RST;
				cfg1_nxt[c] = CFG1_RST;
			end else if (eeTake && ldIdx_r[4:2] == 3'(c)) begin
				case (ldIdx_r[1:0])
					2'h0: cfg0_nxt[c][7:0] = eeData;
					2'h1: cfg0_nxt[c][15:8] = eeData;
					2'h2: cfg1_nxt[c][7:0] = eeData;
					default: cfg1_nxt[c][15:8] = eeData & CFG1_MASK[15:8];
				endcase
			end else if (doWrite && wrDec[5] && wrDec[2:0] == 3'(c)) begin
				if (wrDec[4:3] == 2'h0) begin
					cfg0_nxt[c] = merge(cfg0_r[c], wData_r, wStrb_r);
				end else if (wrDec[4:3] == 2'h1) begin
					// Only magnitudes are stored; tap signs are fixed in the driver
					cfg1_nxt[c] = merge(cfg1_r[c], wData_r, wStrb_r) & CFG1_MASK;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < NUM_CH; c++) begin
				cfg0_r[c] <= CFG0_RST;
				cfg1_r[c] <= CFG1_RST;
			end
			power_r <= '0;
		end else begin
			cfg0_r <= cfg0_nxt;
			cfg1_r <= cfg1_nxt;
			power_r <= power_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic [7:0] eeDev_r;
	logic       doneOut_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eeDev_r <= EE_DEV;
			doneOut_r <= 1'b0;
		end else begin
			eeDev_r <= EE_DEV;
			doneOut_r <= 1'b0;
		end
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : gOut
		assign eq1Bypass[c] = cfg0_r[c][CF_EQ1_BYP];
		assign eq1Boost[c*3+:3] = cfg0_r[c][CF_EQ1+:3];
		assign eq2Boost[c*3+:3] = cfg0_r[c][CF_EQ2+:3];
		assign eqBandwidth[c*2+:2] = cfg0_r[c][CF_BW+:2];
		assign wideGainHi[c] = cfg0_r[c][CF_HIGAIN];
		assign dcGain[c*3+:3] = cfg0_r[c][CF_DC+:3];
		assign limitMode[c] = cfg0_r[c][CF_LIMIT];
		assign firMain[c*5+:5] = cfg1_r[c][CF_MAIN+:5];
		assign firPre[c*4+:4] = cfg1_r[c][CF_PRE+:4];
		assign firPost[c*4+:4] = cfg1_r[c][CF_POST+:4];

		a_auto_power: assert property (@(posedge clk) disable iff (rst)
			!cfg0_r[c][CF_SD_FORCE] |=> power_r[c] == $past(sdLvl[c]))
			else $error("auto power does not follow detect");
		a_force_off: assert property (@(posedge clk) disable iff (rst)
			cfg0_r[c][CF_SD_FORCE] && !cfg0_r[c][CF_SD_ON] |=> !power_r[c])
			else $error("forced channel not powered down");
		a_tap_sign: assert property (@(posedge clk) disable iff (rst)
			cfg1_r[c][15:13] == 3'h0)
			else $error("tap sign bits stored");
	end

	assign chPowerOn = power_r;
	assign slaveAddr = slaveAddr_r;
	assign writeByte = writeByte_r;
	assign doneNOut = doneOut_r;
	assign doneNOe = doneOe_r;
	assign eeReq = eeReq_r;
	assign eeDevAddr = eeDev_r;
	assign eeByteAddr = {5'h00, ldIdx_r};
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_strap_addr: assert property ($changed(st_r) && $past(st_r) == ST_POR |->
		slaveAddr_r == SLAVE_BASE + {3'h0, $past(hiLvl), $past(loLvl)})
		else $error("slave address not from straps");
	a_addr_hold: assert property (st_r != ST_POR && $past(st_r) != ST_POR |->
		$stable(slaveAddr_r))
		else $error("slave address changed after capture");
	a_write_byte: assert property (st_r != ST_POR |-> writeByte_r == {slaveAddr_r, 1'b0})
		else $error("write byte mismatch");
	a_pin_reset: assert property (pinReset && !eeTake |=>
		cfg0_r[0] == CFG0_RST && cfg1_r[NUM_CH-1] == CFG1_RST)
		else $error("load pin did not reset registers");
	a_done_drive: assert property (slaveMode_r && st_r == ST_IDLE |=>
		doneOe_r == !$past(loadNLvl))
		else $error("done pin does not follow load pin");
	a_ee_finish: assert property (eeTake && ldIdx_r == EE_LAST |=>
		st_r == ST_DONE && doneOe_r && !eeReq_r)
		else $error("load end not flagged");
	a_load_start: assert property (!slaveMode_r && st_r == ST_IDLE && !loadNLvl |=>
		eeReq_r && ldIdx_r == 5'h00)
		else $error("load did not start");
	a_write_resp: assert property (doWrite |=> bvalid_r ##0 !awHeld_r)
		else $error("write not answered");
	a_read_resp: assert property (arvalid && arready_r |=> rvalid_r)
		else $error("read not answered");

	c_ee_load: cover property (eeTake && ldIdx_r == EE_LAST);
	c_pin_reset: cover property (pinReset);
	c_bus_write: cover property (doWrite && wrDec[4:3] == 2'h1);
	c_force_on: cover property (cfg0_r[0][CF_SD_FORCE] && power_r[0] && !sdLvl[0]);
endmodule
`default_nettype wire

/* rcc_ee_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rcc_ee_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       eeReq,
	input  wire logic [7:0] eeDevAddr,
	input  wire logic [9:0] eeByteAddr,
	input  wire logic [1:0] lag,
	output logic      [7:0] eeData,
	output logic            eeAck
);
	// ----------------------------------------------------------------
	// Byte store with a selectable answer delay
	// ----------------------------------------------------------------
	logic [1:0] waitCnt;

	// Only device 0xa0 answers, so a wrong device address hangs the load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eeAck   <= 1'b0;
			eeData  <= 8'h00;
			waitCnt <= 2'h0;
		end else if (eeReq && !eeAck && eeDevAddr == 8'ha0 && waitCnt == lag) begin
			eeAck   <= 1'b1;
			eeData  <= 8'(eeByteAddr * 37 + 5);
			waitCnt <= 2'h0;
		end else begin
			eeAck   <= 1'b0;
			// Data is not held past the ack; toggling exposes a late sample
			eeData  <= ~eeData;
			waitCnt <= (eeReq && !eeAck && waitCnt != lag) ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

/* repeater_channel_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module repeater_channel_control_tb import rcc_pkg::*;;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, mgmtModeStrap = 1'b1, loadReqN = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sigDetect = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  addrStrapHi = 2'h0, addrStrapLo = 2'h0, lag = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid, doneNOut, doneNOe, eeReq, eeAck;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, firPre, firPost;
	logic [7:0]  eeDevAddr, eeData, writeByte, chPowerOn, eq1Bypass, wideGainHi, limitMode;
	logic [9:0]  eeByteAddr;
	logic [6:0]  slaveAddr;
	logic [23:0] eq1Boost, eq2Boost, dcGain;
	logic [15:0] eqBandwidth;
	logic [39:0] firMain;
	int          errorCnt = 0, testsRun = 0;

	rcc_ctrl #(.PorCycles(16)) uut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sigDetect, .addrStrapHi, .addrStrapLo, .mgmtModeStrap,
		.loadReqN, .doneNOut, .doneNOe, .eeReq, .eeDevAddr, .eeByteAddr, .eeData, .eeAck,
		.slaveAddr, .writeByte, .chPowerOn, .eq1Bypass, .eq1Boost, .eq2Boost, .eqBandwidth,
		.wideGainHi, .dcGain, .limitMode, .firMain, .firPre, .firPost);
	rcc_ee_model em (.clk, .rst, .eeReq, .eeDevAddr, .eeByteAddr, .lag, .eeData, .eeAck);

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [39:0] s, input logic [39:0] e);
		testsRun++;
		if (s !== e) begin
			errorCnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic endOfTest();
		$display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic rstp();
		@(posedge clk);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 400);
		chk({n >= 400, bresp}, {1'b0, er});
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!arready && n < 400);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (!rvalid && n < 400);
		chk({n >= 400, rresp}, {1'b0, er});
		chk(rdata, e);
		rready <= 1'b0;
	endtask
	function automatic logic [15:0] cfgA(int c);
		logic [2:0] b;
		b = 3'(c);
		return {b[0], ~b, b[1], b[1:0], ~b, b, b[2], 2'b00};
	endfunction
	function automatic logic [15:0] cfgB(int c);
		logic [2:0] b;
		b = 3'(c);
		return {3'b111, b, 1'b1, ~{1'b0, b}, b, 2'b10};
	endfunction
	function automatic logic [7:0] eeb(int i);
		return 8'(i * 37 + 5);
	endfunction

	initial begin
		logic [15:0] v;
		logic [6:0]  sa;
		int          n;
		for (int i = 0; i < 16; i++) begin
			addrStrapHi <= 2'(i >> 2);
			addrStrapLo <= 2'(i);
			rstp();
			sa = 7'h18 + 7'(i);
			axr(OFF_STRAP, {14'h0, 1'b0, 1'b1, sa, 2'b00, sa}, RESP_OK);
			chk({writeByte, slaveAddr}, {sa, 1'b0, sa});
		end
		addrStrapHi <= 2'h0;
		addrStrapLo <= 2'h0;
		repeat (8) @(posedge clk);
		chk(slaveAddr, 7'h27);
		$display("strap test done");
		for (int c = 0; c < 8; c++) begin
			axr(8'(c * 16) + OFF_CFG0, 32'(CFG0_RST), RESP_OK);
			axr(8'(c * 16) + OFF_CFG1, 32'(CFG1_RST), RESP_OK);
			// Limiting mode only on odd channels: the bench models no link training
			axw(8'(c * 16) + OFF_CFG0, {16'hffff, cfgA(c)}, RESP_OK);
			axw(8'(c * 16) + OFF_CFG1, {16'hffff, cfgB(c)}, RESP_OK);
		end
		for (int c = 0; c < 8; c++) begin
			axr(8'(c * 16) + OFF_CFG0, 32'(cfgA(c)), RESP_OK);
			axr(8'(c * 16) + OFF_CFG1, 32'(cfgB(c) & CFG1_MASK), RESP_OK);
			v = cfgA(c);
			chk(eq1Bypass[c], v[CF_EQ1_BYP]);
			chk(eq1Boost[c * 3 +: 3], v[CF_EQ1 +: 3]);
			chk(eq2Boost[c * 3 +: 3], v[CF_EQ2 +: 3]);
			chk(eqBandwidth[c * 2 +: 2], v[CF_BW +: 2]);
			chk(wideGainHi[c], v[CF_HIGAIN]);
			chk(dcGain[c * 3 +: 3], v[CF_DC +: 3]);
			chk(limitMode[c], v[CF_LIMIT]);
			v = cfgB(c);
			chk(firMain[c * 5 +: 5], v[CF_MAIN +: 5]);
			chk({firPre[c * 4 +: 4], firPost[c * 4 +: 4]}, {v[CF_PRE +: 4], v[CF_POST +: 4]});
		end
		$display("config test done");
		sigDetect <= 8'ha5;
		repeat (6) @(posedge clk);
		chk(chPowerOn, 8'ha5);
		axr(OFF_STAT, 32'h3, RESP_OK);
		axw(8'h20, 32'h1, RESP_OK);
		axw(8'h10, 32'h3, RESP_OK);
		repeat (2) @(posedge clk);
		chk(chPowerOn, 8'ha3);
		axr(8'h18, 32'h1, RESP_OK);
		sigDetect <= 8'h00;
		repeat (6) @(posedge clk);
		chk(chPowerOn, 8'h02);
		$display("detect test done");
		axw(8'h84, 32'h1, RESP_ERR);
		axr(8'h84, 32'h0, RESP_ERR);
		axw(OFF_STRAP, 32'hffff, RESP_ERR);
		axw(OFF_STAT, 32'h3, RESP_ERR);
		axr(OFF_STRAP, {14'h0, 1'b0, 1'b1, 7'h27, 2'b00, 7'h27}, RESP_OK);
		$display("access test done");
		loadReqN <= 1'b0;
		repeat (6) @(posedge clk);
		chk({doneNOe, doneNOut, eeReq}, 3'b100);
		chk(eq2Boost, 24'h0);
		chk(firMain, {8{5'h1f}});
		loadReqN <= 1'b1;
		repeat (6) @(posedge clk);
		chk(doneNOe, 1'b0);
		axr(8'h30, 32'h0, RESP_OK);
		$display("load pin test done");
		for (int k = 0; k < 2; k++) begin
			lag <= 2'(k * 2);
			mgmtModeStrap <= 1'b0;
			loadReqN <= 1'b1;
			rstp();
			repeat (40) @(posedge clk);
			chk({eeReq, doneNOe}, 2'b00);
			loadReqN <= 1'b0;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!eeReq && n < 100);
			chk(eeDevAddr, 8'ha0);
			do begin
				@(posedge clk);
				n++;
			end while (!doneNOe && n < 2000);
			chk({eeReq, doneNOe, doneNOut}, 3'b010);
			for (int c = 0; c < 8; c++) begin
				axr(8'(c * 16) + OFF_CFG0, {eeb(4 * c + 1), eeb(4 * c)}, RESP_OK);
				v = {eeb(4 * c + 3), eeb(4 * c + 2)} & CFG1_MASK;
				axr(8'(c * 16) + OFF_CFG1, 32'(v), RESP_OK);
			end
			axr(OFF_STRAP, {14'h0, 1'b1, 1'b0, 7'h18, 2'b00, 7'h18}, RESP_OK);
		end
		$display("eeprom test done");
		endOfTest();
	end

	initial begin
		repeat (30000) @(posedge clk);
		errorCnt++;
		endOfTest();
	end
endmodule
`default_nettype wire
